// ==== logic/sutc_pkg.sv ====
// Constants for the serial transmit control block: offsets, fields,
// reset values, baud prescales and the transmitter state type.
// Assumes a 200 MHz core clock and a 32-bit Avalon-MM register bus.
package sutc_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_TXSC   = 8'h98;
  localparam logic [7:0] OFF_RXSC   = 8'h9C;
  localparam logic [7:0] OFF_DIR    = 8'hA0;
  localparam logic [7:0] OFF_TXDATA = 8'hA4;
  localparam logic [7:0] OFF_BAUD   = 8'hA8;
  localparam logic [7:0] OFF_ISTAT  = 8'hAC;
  localparam logic [7:0] OFF_IMASK  = 8'hB0;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int TXSC_CLK_SRC = 7;
  localparam int TXSC_NINE    = 6;
  localparam int TXSC_TX_ON   = 5;
  localparam int TXSC_SYNC    = 4;
  localparam int TXSC_HIGH    = 2;
  localparam int TXSC_EMPTY   = 1;
  localparam int TXSC_NINTH   = 0;
  localparam logic [7:0] TXSC_WR_MASK = 8'hF5;
  localparam logic [7:0] TXSC_RST     = 8'h00;
  localparam int RXSC_PORT_ON = 7;
  localparam int RXSC_SINGLE  = 5;
  localparam int RXSC_CONT    = 4;
  localparam logic [7:0] RXSC_WR_MASK = 8'hB0;
  localparam logic [7:0] RXSC_RST     = 8'h00;
  localparam int DIR_TX_PIN = 6;
  localparam int DIR_RX_PIN = 7;
  localparam logic [7:0] DIR_WR_MASK = 8'hC0;
  localparam logic [7:0] DIR_RST     = 8'hC0;
  localparam logic [7:0] BAUD_RST    = 8'h00;
  localparam int IRQ_BUF  = 0;
  localparam int IRQ_DONE = 1;
  localparam logic [1:0] IRQ_RST = 2'h0;

  // ----------------------------------------------------------------
  // Baud prescales: clocks per bit per divisor step
  // ----------------------------------------------------------------
  localparam logic [6:0] PRE_HIGH = 7'h10;
  localparam logic [6:0] PRE_LOW  = 7'h40;
  localparam logic [6:0] PRE_SYNC = 7'h04;

  typedef enum logic [1:0] {
    SUTC_IDLE  = 2'b00,
    SUTC_START = 2'b01,
    SUTC_DATA  = 2'b10,
    SUTC_STOP  = 2'b11
  } sutc_state_t;
endpackage : sutc_pkg

// ==== logic/sutc_eng_if.sv ====
// Bundle between the register side and the transmit engine.
// Assumes both ends share one clock.
`timescale 1ns/100ps
interface sutc_eng_if;
  logic       sync;
  logic       master;
  logic       nine;
  logic       enable;
  logic       high;
  logic [7:0] div;
  logic       load;
  logic [8:0] data;
  logic       ck_in;
  logic       empty;
  logic       done;
  logic       line;
  logic       ck_out;

  modport ctrl (output sync, master, nine, enable, high, div, load, data, ck_in,
                input  empty, done, line, ck_out);
  modport eng  (input  sync, master, nine, enable, high, div, load, data, ck_in,
                output empty, done, line, ck_out);
endinterface : sutc_eng_if

// ==== logic/sutc_engine.sv ====
// Transmit shift engine: async frames, sync master and sync slave.
// Assumes ck_in is already synchronised to clock.
`timescale 1ns/100ps
module sutc_engine (
  input  wire logic  clock,
  input  wire logic  nrst,
  sutc_eng_if.eng    e
);
  sutc_pkg::sutc_state_t st_q, st_d;
  logic [8:0]  sh_q, sh_d;
  logic [3:0]  bit_q, bit_d;
  logic [15:0] cnt_q, cnt_d;
  logic        line_q, line_d;
  logic        ck_q, ck_d;
  logic        ckp_q;
  logic        done_q, done_d;
  logic [6:0]  pre;
  logic [15:0] per;
  logic        tick;
  logic        adv;
  logic [3:0]  last;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    pre  = e.sync ? sutc_pkg::PRE_SYNC : (e.high ? sutc_pkg::PRE_HIGH : sutc_pkg::PRE_LOW);
    per  = 16'(pre) * (16'(e.div) + 16'h0001);
    tick = (cnt_q == 16'h0000);
    // slave shifts on external clock fall
    adv  = (e.sync && !e.master) ? (ckp_q && !e.ck_in) : tick;
    last = e.nine ? 4'h8 : 4'h7;
    st_d   = st_q;
    sh_d   = sh_q;
    bit_d  = bit_q;
    cnt_d  = tick ? per - 16'h0001 : cnt_q - 16'h0001;
    line_d = line_q;
    done_d = 1'b0;
    case (st_q)
      sutc_pkg::SUTC_IDLE: begin
        line_d = 1'b1;
        if (e.load && e.enable) begin
          sh_d   = e.data;
          bit_d  = 4'h0;
          cnt_d  = per - 16'h0001;
          // sync skips start and stop bits
          st_d   = e.sync ? sutc_pkg::SUTC_DATA : sutc_pkg::SUTC_START;
          line_d = e.sync ? e.data[0] : 1'b0;
        end
      end
      sutc_pkg::SUTC_START: begin
        if (tick) begin
          st_d   = sutc_pkg::SUTC_DATA;
          line_d = sh_q[0];
        end
      end
      sutc_pkg::SUTC_DATA: begin
        if (adv) begin
          if (bit_q == last) begin
            st_d   = e.sync ? sutc_pkg::SUTC_IDLE : sutc_pkg::SUTC_STOP;
            line_d = 1'b1;
            done_d = e.sync;
          end else begin
            bit_d  = bit_q + 4'h1;
            sh_d   = {1'b0, sh_q[8:1]};
            line_d = sh_q[1];
          end
        end
      end
      default: begin
        if (tick) begin
          st_d   = sutc_pkg::SUTC_IDLE;
          done_d = 1'b1;
        end
      end
    endcase
    // dropping the gate aborts the frame
    if (!e.enable) begin
      st_d   = sutc_pkg::SUTC_IDLE;
      line_d = 1'b1;
    end
    // master clock high in second half of bit
    ck_d = e.sync && e.master && (st_d == sutc_pkg::SUTC_DATA) && (cnt_d < {1'b0, per[15:1]});
  end

  // Registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_q   <= sutc_pkg::SUTC_IDLE;
      sh_q   <= 9'h000;
      bit_q  <= 4'h0;
      cnt_q  <= 16'h0000;
      line_q <= 1'b1;
      ck_q   <= 1'b0;
      ckp_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      sh_q   <= sh_d;
      bit_q  <= bit_d;
      cnt_q  <= cnt_d;
      line_q <= line_d;
      ck_q   <= ck_d;
      ckp_q  <= e.ck_in;
      done_q <= done_d;
    end
  end

  assign e.empty  = (st_q == sutc_pkg::SUTC_IDLE);
  assign e.done   = done_q;
  assign e.line   = line_q;
  assign e.ck_out = ck_q;
endmodule : sutc_engine

// ==== logic/sutc_top.sv ====
// Serial transmit control block with Avalon-MM register slave,
// one-word transmit buffer, interrupt logic and pin steering.
// Assumes pins arrive asynchronously and are resolved by the bench.
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/100ps

// How it works
// - Three modes: async full duplex, sync master and sync slave half duplex.
// - Bit 7 in sync picks master with internal clock or slave.
// - Bit 5 enables the transmitter; clear disables it.
// - In sync mode a receive enable overrides the transmit enable.
// - Bit 3 is unimplemented, reads zero, ignores writes.
// - Bit 2 picks high or low baud range, async only.
// - Read-only bit 1 is one while the shift register is empty.
// - Bit 0 holds the ninth transmitted bit, usable as parity.
// - Reset clears writable bits; empty status reads one.
module sutc_top (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  input  wire logic        tx_ck_in,
  output logic             tx_ck_out,
  output logic             tx_ck_oe,
  input  wire logic        rx_dt_in,
  output logic             rx_dt_out,
  output logic             rx_dt_oe
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sutc_eng_if eif ();
  logic [1:0]  pin_raw;
  logic [1:0]  sync1_q;
  logic [1:0]  sync2_q;
  logic        ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0]  txsc_q, txsc_d;
  logic [7:0]  rxsc_q, rxsc_d;
  logic [7:0]  dir_q, dir_d;
  logic [7:0]  baud_q, baud_d;
  logic [8:0]  buf_q, buf_d;
  logic        full_q, full_d;
  logic [1:0]  istat_q, istat_d;
  logic [1:0]  imask_q, imask_d;
  logic        irq_q, irq_d;
  logic [7:0]  txsc_rd;
  logic        req;
  logic        wr;
  logic        rd;
  logic        port_on;
  logic        rx_prio;
  logic        en;
  logic        ld;
  logic [1:0]  ev;

  // Address match used for both read and write decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  assign pin_raw = {rx_dt_in, tx_ck_in};

  // Two flops per incoming pin
  generate
    for (genvar i = 0; i < 2; i++) begin : g_sync
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          sync1_q[i] <= 1'b0;
          sync2_q[i] <= 1'b0;
        end else begin
          sync1_q[i] <= pin_raw[i];
          sync2_q[i] <= sync1_q[i];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // One wait cycle; a write lands on the edge after the wait, with waitrequest low
  assign req             = avs_read || avs_write;
  assign avs_waitrequest = req && !ack_q;
  assign wr              = avs_write && ack_q;
  assign rd              = avs_read && !ack_q;

  // Status view of the control register
  always_comb begin
    txsc_rd = txsc_q & sutc_pkg::TXSC_WR_MASK;
    txsc_rd[sutc_pkg::TXSC_EMPTY] = eif.empty;
  end

  // Read data mux, latched on the first cycle
  always_comb begin
    ack_d   = req && !ack_q;
    rdata_d = rdata_q;
    if (rd) begin
      rdata_d = 32'h0000_0000;
      // bit 3 always zero through the mask
      if (hit(avs_address, sutc_pkg::OFF_TXSC)) begin
        rdata_d[7:0] = txsc_rd;
      end else if (hit(avs_address, sutc_pkg::OFF_RXSC)) begin
        rdata_d[7:0] = rxsc_q;
      end else if (hit(avs_address, sutc_pkg::OFF_DIR)) begin
        rdata_d[7:0] = dir_q;
      end else if (hit(avs_address, sutc_pkg::OFF_TXDATA)) begin
        rdata_d[8:0] = buf_q;
      end else if (hit(avs_address, sutc_pkg::OFF_BAUD)) begin
        rdata_d[7:0] = baud_q;
      end else if (hit(avs_address, sutc_pkg::OFF_ISTAT)) begin
        rdata_d[1:0] = istat_q;
      end else if (hit(avs_address, sutc_pkg::OFF_IMASK)) begin
        rdata_d[1:0] = imask_q;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata = rdata_q;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Writes honour byte lane 0 only; no field is wider than a byte
  always_comb begin
    txsc_d  = txsc_q;
    rxsc_d  = rxsc_q;
    dir_d   = dir_q;
    baud_d  = baud_q;
    imask_d = imask_q;
    if (wr && avs_byteenable[0]) begin
      if (hit(avs_address, sutc_pkg::OFF_TXSC)) begin
        txsc_d = avs_writedata[7:0] & sutc_pkg::TXSC_WR_MASK;
      end else if (hit(avs_address, sutc_pkg::OFF_RXSC)) begin
        rxsc_d = avs_writedata[7:0] & sutc_pkg::RXSC_WR_MASK;
      end else if (hit(avs_address, sutc_pkg::OFF_DIR)) begin
        dir_d = avs_writedata[7:0] & sutc_pkg::DIR_WR_MASK;
      end else if (hit(avs_address, sutc_pkg::OFF_BAUD)) begin
        baud_d = avs_writedata[7:0];
      end else if (hit(avs_address, sutc_pkg::OFF_IMASK)) begin
        imask_d = avs_writedata[1:0];
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      txsc_q  <= sutc_pkg::TXSC_RST;
      rxsc_q  <= sutc_pkg::RXSC_RST;
      dir_q   <= sutc_pkg::DIR_RST;
      baud_q  <= sutc_pkg::BAUD_RST;
      imask_q <= sutc_pkg::IRQ_RST;
    end else begin
      txsc_q  <= txsc_d;
      rxsc_q  <= rxsc_d;
      dir_q   <= dir_d;
      baud_q  <= baud_d;
      imask_q <= imask_d;
    end
  end

  // ----------------------------------------------------------------
  // Transmit gate and buffer
  // ----------------------------------------------------------------
  // pins serve only with port and both directions set
  assign port_on = rxsc_q[sutc_pkg::RXSC_PORT_ON] && dir_q[sutc_pkg::DIR_TX_PIN]
                   && dir_q[sutc_pkg::DIR_RX_PIN];
  // receive enable wins in sync mode
  assign rx_prio = txsc_q[sutc_pkg::TXSC_SYNC]
                   && (rxsc_q[sutc_pkg::RXSC_SINGLE] || rxsc_q[sutc_pkg::RXSC_CONT]);
  assign en      = txsc_q[sutc_pkg::TXSC_TX_ON] && port_on && !rx_prio;
  assign ld      = full_q && eif.empty && en;

  // Buffer fill by data write, drain into the shifter
  always_comb begin
    buf_d  = buf_q;
    full_d = full_q;
    if (ld) begin
      full_d = 1'b0;
    end
    if (wr && avs_byteenable[0] && !full_q && hit(avs_address, sutc_pkg::OFF_TXDATA)) begin
      // ninth bit captured with the byte
      buf_d  = {txsc_q[sutc_pkg::TXSC_NINTH], avs_writedata[7:0]};
      full_d = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      buf_q  <= 9'h000;
      full_q <= 1'b0;
    end else begin
      buf_q  <= buf_d;
      full_q <= full_d;
    end
  end

  // ----------------------------------------------------------------
  // Engine hookup
  // ----------------------------------------------------------------
  // mode select
  assign eif.sync   = txsc_q[sutc_pkg::TXSC_SYNC];
  assign eif.master = txsc_q[sutc_pkg::TXSC_CLK_SRC];
  assign eif.nine   = txsc_q[sutc_pkg::TXSC_NINE];
  assign eif.high   = txsc_q[sutc_pkg::TXSC_HIGH];
  assign eif.enable = en;
  assign eif.div    = baud_q;
  assign eif.load   = ld;
  assign eif.data   = buf_q;
  assign eif.ck_in  = sync2_q[0];

  sutc_engine u_engine (
    .clock (clock),
    .nrst  (nrst),
    .e     (eif)
  );

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign ev = {eif.done, ld};

  // Sticky status, read clears, a new event wins over the clear
  always_comb begin
    istat_d = istat_q;
    if (rd && hit(avs_address, sutc_pkg::OFF_ISTAT)) begin
      istat_d = 2'h0;
    end
    istat_d = istat_d | ev;
    irq_d   = |(istat_d & imask_d);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      istat_q <= sutc_pkg::IRQ_RST;
      irq_q   <= 1'b0;
    end else begin
      istat_q <= istat_d;
      irq_q   <= irq_d;
    end
  end

  assign irq = irq_q;

  // ----------------------------------------------------------------
  // Pin steering
  // ----------------------------------------------------------------
  // sync: clock on transmit pin, data on receive pin
  always_comb begin
    tx_ck_out = 1'b1;
    tx_ck_oe  = 1'b0;
    rx_dt_out = 1'b1;
    rx_dt_oe  = 1'b0;
    if (port_on) begin
      if (!eif.sync) begin
        tx_ck_out = eif.line;
        tx_ck_oe  = 1'b1;
      end else begin
        tx_ck_out = eif.ck_out;
        tx_ck_oe  = eif.master;
        rx_dt_out = eif.line;
        rx_dt_oe  = en;
      end
    end
  end
endmodule : sutc_top

// ==== test/sutc_far_end.sv ====
// Far-end model: a terminal or sync peripheral on the two pins.
// Assumes the bench resolves both pins, with pull-ups when released.
`timescale 1ns/100ps
module sutc_far_end (
  input  wire logic       clock,
  input  wire logic       tx_pin,
  input  wire logic       rx_pin,
  input  wire logic       sync,
  input  wire logic       nine,
  input  wire logic       clr,
  input  wire logic       slave_run,
  input  wire logic [7:0] bit_clks,
  output logic      [8:0] word,
  output logic            stop_bit,
  output int              count,
  output logic            slave_ck
);
  logic [8:0] sh;
  logic [8:0] ss;
  logic       prev;
  int         k;
  int         hc;
  int         np;
  // ----------------------------------------------------------------
  // Async receiver
  // ----------------------------------------------------------------
  // start, data LSB first, stop
  initial begin
    count = 0;
    prev = 1'b1;
    forever begin
      @(posedge clock);
      if (!sync && prev && !tx_pin) begin
        repeat (bit_clks / 2) @(posedge clock);
        sh = 9'h000;
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
          repeat (bit_clks) @(posedge clock);
          sh[i] = tx_pin;
        end
        repeat (bit_clks) @(posedge clock);
        stop_bit = tx_pin;
        word = sh;
        count++;
      end
      prev = tx_pin;
    end
  end
  // sync data sampled on clock rise
  always @(posedge tx_pin) begin
    if (sync) begin
      ss[k] = rx_pin;
      k++;
      if (k == (nine ? 9 : 8)) begin
        word = nine ? ss : {1'b0, ss[7:0]};
        k = 0;
        count++;
      end
    end
  end
  // Bit counter restart between modes
  always @(posedge clr) begin
    k = 0;
    ss = 9'h000;
  end
  // external clock for slave mode: idle low, one pulse per bit
  always @(posedge clock) begin
    if (!slave_run) begin
      hc = 0;
      np = 0;
      slave_ck <= 1'b0;
    end else if (hc == 15 && np < (nine ? 18 : 16)) begin
      hc = 0;
      np++;
      slave_ck <= ~slave_ck;
    end else begin
      hc++;
    end
  end
endmodule : sutc_far_end

// ==== test/sutc_checker_properties.sv ====
// Assertions on the ports of the serial transmit control top.
// Assumes the register offsets and fields of the package.
`timescale 1ns/100ps
module sutc_checker (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        irq,
  input wire logic        tx_ck_in,
  input wire logic        tx_ck_out,
  input wire logic        tx_ck_oe,
  input wire logic        rx_dt_in,
  input wire logic        rx_dt_out,
  input wire logic        rx_dt_oe
);
  logic sync_q, mst_q, ton_q, pon_q, rxen_q, dir_q;
  logic gate_w, slave_w, async_w, rd_ok, wr_ok;
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign rd_ok = avs_read && !avs_waitrequest;
  assign gate_w = ton_q && pon_q && dir_q && !(sync_q && rxen_q);
  assign slave_w = sync_q && !mst_q;
  assign async_w = !sync_q;
  // Shadow of the control bits written over the bus
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      {sync_q, mst_q, ton_q, pon_q, rxen_q} <= 5'h00;
      dir_q <= 1'b1;
    end else if (wr_ok) begin
      if (avs_address == sutc_pkg::OFF_TXSC) {mst_q, ton_q, sync_q} <= {avs_writedata[7], avs_writedata[5:4]};
      if (avs_address == sutc_pkg::OFF_RXSC) {pon_q, rxen_q} <= {avs_writedata[7], |avs_writedata[5:4]};
      if (avs_address == sutc_pkg::OFF_DIR) dir_q <= &avs_writedata[7:6];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // Bus answer after one wait cycle
  a_wait_one: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read not answered after one wait cycle");
  a_read_clean: assert property (rd_ok && avs_address == sutc_pkg::OFF_TXSC |-> avs_readdata[31:8] == 24'h0
    && !avs_readdata[3]) else $error("control read shows unimplemented bits");
  // Reads of unmapped offset 8'h00 return zero
  a_hole_zero: assert property (rd_ok && avs_address == 8'h00 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_gate_shut: assert property (!gate_w && !$past(gate_w) |-> !rx_dt_oe)
    else $error("data pin driven with gate closed");
  a_async_rxpin: assert property (async_w && $past(async_w) |-> !rx_dt_oe)
    else $error("data pin driven in async mode");
  a_slave_clock: assert property (slave_w && $past(slave_w) |-> !tx_ck_oe)
    else $error("clock pin driven in slave mode");
  a_reset_quiet: assert property ($rose(nrst) |-> !irq && !tx_ck_oe && !rx_dt_oe)
    else $error("outputs active after reset");
  a_sync_stable: assert property (rx_dt_oe && tx_ck_oe && tx_ck_out && $past(tx_ck_out) |-> $stable(rx_dt_out))
    else $error("sync data moved while clock high");
endmodule : sutc_checker
bind sutc_top sutc_checker sutc_checker_inst (.clock(clock), .nrst(nrst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .tx_ck_in(tx_ck_in),
  .tx_ck_out(tx_ck_out), .tx_ck_oe(tx_ck_oe), .rx_dt_in(rx_dt_in), .rx_dt_out(rx_dt_out), .rx_dt_oe(rx_dt_oe));

// ==== test/tb_serial_usart_transmit_control.sv ====
// Testbench: register tasks over Avalon-MM and frame checks.
// Assumes pull-ups on both pins and the far-end model.
`timescale 1ns/100ps
module tb_serial_usart_transmit_control;
  logic        clock = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0]  avs_address = 8'h00, bit_clks = 8'h10;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [3:0]  avs_byteenable = 4'hF;
  logic        avs_waitrequest, irq, tx_ck_out, tx_ck_oe, rx_dt_out, rx_dt_oe, slave_ck, far_stop;
  logic        far_sync = 1'b0, far_nine = 1'b0, far_clr = 1'b0, slave_run = 1'b0;
  logic [8:0]  far_word;
  int          far_count, n_seen = 0, err_total = 0, n_compared = 0;
  wire tx_pin = tx_ck_oe ? tx_ck_out : (slave_run ? slave_ck : 1'b1);
  wire rx_pin = rx_dt_oe ? rx_dt_out : 1'b1;
  always #2.5 clock = ~clock;
  sutc_top sutc_top_inst (.clock(clock), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .tx_ck_in(tx_pin),
    .tx_ck_out(tx_ck_out), .tx_ck_oe(tx_ck_oe), .rx_dt_in(rx_pin), .rx_dt_out(rx_dt_out), .rx_dt_oe(rx_dt_oe));
  sutc_far_end sutc_far_end_inst (.clock(clock), .tx_pin(tx_pin), .rx_pin(rx_pin), .sync(far_sync),
    .nine(far_nine), .clr(far_clr), .slave_run(slave_run), .bit_clks(bit_clks), .word(far_word),
    .stop_bit(far_stop), .count(far_count), .slave_ck(slave_ck));
  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Hold request until waitrequest is low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    avs_address <= a;
    avs_writedata <= d;
    if (wr) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0 && t < 50) begin
      @(posedge clock);
      t++;
    end
    if (t >= 50) check("bus answer", 32'h0, 32'h1);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask : bus
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check($sformatf("reg %h", a), exp, rd);
  endtask : rd_chk
  // Wait for one decoded frame, its done interrupt, then clear status
  task automatic frame_done(input logic [8:0] exp);
    int t;
    t = 0;
    while (far_count == n_seen && t < 3000) begin
      @(posedge clock);
      t++;
    end
    check("frame seen", 32'h1, {31'h0, far_count != n_seen});
    n_seen = far_count;
    check("far word", {23'h0, exp}, {23'h0, far_word});
    if (!far_sync) check("stop bit", 32'h1, {31'h0, far_stop});
    t = 0;
    while (irq !== 1'b1 && t < 200) begin
      @(posedge clock);
      t++;
    end
    check("irq raised", 32'h1, {31'h0, irq});
    rd_chk(sutc_pkg::OFF_ISTAT, 32'h3);
  endtask : frame_done
  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  // Watchdog against a hung handshake or frame
  initial begin
    #200000;
    err_total++;
    $display("Error watchdog expected end seen hang");
    stop_test();
  end
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rd_chk(sutc_pkg::OFF_TXSC, 32'h02);
    rd_chk(sutc_pkg::OFF_DIR, 32'hC0);
    rd_chk(sutc_pkg::OFF_RXSC, 32'h00);
    bus(1'b1, sutc_pkg::OFF_TXSC, 32'hFF);
    rd_chk(sutc_pkg::OFF_TXSC, 32'hF7);
    bus(1'b1, 8'h00, 32'hFF);
    rd_chk(8'h00, 32'h0);
    $display("test registers done");
    // port on, async high speed eight bits
    bus(1'b1, sutc_pkg::OFF_TXSC, 32'h00);
    bus(1'b1, sutc_pkg::OFF_BAUD, 32'h00);
    bus(1'b1, sutc_pkg::OFF_IMASK, 32'h02);
    bus(1'b1, sutc_pkg::OFF_RXSC, 32'h80);
    bus(1'b1, sutc_pkg::OFF_TXSC, 32'h24);
    bus(1'b1, sutc_pkg::OFF_TXDATA, 32'hA5);
    rd_chk(sutc_pkg::OFF_TXSC, 32'h24);
    check("masked irq", 32'h0, {31'h0, irq});
    frame_done(9'h0A5);
    rd_chk(sutc_pkg::OFF_ISTAT, 32'h0);
    check("irq cleared", 32'h0, {31'h0, irq});
    rd_chk(sutc_pkg::OFF_TXSC, 32'h26);
    $display("test async eight done");
    bit_clks <= 8'h40;
    far_nine <= 1'b1;
    bus(1'b1, sutc_pkg::OFF_TXSC, 32'h61);
    bus(1'b1, sutc_pkg::OFF_TXDATA, 32'h3C);
    frame_done(9'h13C);
    $display("test async nine done");
    // gate closed holds the data back
    bit_clks <= 8'h10;
    far_nine <= 1'b0;
    bus(1'b1, sutc_pkg::OFF_TXSC, 32'h04);
    bus(1'b1, sutc_pkg::OFF_TXDATA, 32'h81);
    repeat (300) @(posedge clock);
    check("frames while off", n_seen, far_count);
    check("idle line", 32'h1, {31'h0, tx_pin});
    bus(1'b1, sutc_pkg::OFF_TXSC, 32'h24);
    frame_done(9'h081);
    $display("test gate done");
    far_sync <= 1'b1;
    bus(1'b1, sutc_pkg::OFF_TXSC, 32'hB4);
    far_clr <= 1'b1;
    @(posedge clock);
    far_clr <= 1'b0;
    bus(1'b1, sutc_pkg::OFF_TXDATA, 32'h5A);
    frame_done(9'h05A);
    $display("test sync master done");
    bus(1'b1, sutc_pkg::OFF_RXSC, 32'h90);
    bus(1'b1, sutc_pkg::OFF_TXDATA, 32'h11);
    repeat (100) @(posedge clock);
    check("frames in receive", n_seen, far_count);
    check("data pin oe", 32'h0, {31'h0, rx_dt_oe});
    bus(1'b1, sutc_pkg::OFF_RXSC, 32'h80);
    frame_done(9'h011);
    $display("test override done");
    slave_run <= 1'b1;
    bus(1'b1, sutc_pkg::OFF_TXSC, 32'h30);
    bus(1'b1, sutc_pkg::OFF_TXDATA, 32'h66);
    repeat (40) @(posedge clock);
    @(negedge clock);
    check("slave clock oe", 32'h0, {31'h0, tx_ck_oe});
    check("slave data oe", 32'h1, {31'h0, rx_dt_oe});
    frame_done(9'h066);
    slave_run <= 1'b0;
    $display("test sync slave done");
    stop_test();
  end
endmodule : tb_serial_usart_transmit_control
